// *** src/persistence_and_pulse_config.sv ***
// Purpose: persistence filters, wait extension and emitter pulse control
// Assumes: result strobes come from logic on sys_clk_i; near_sat_i is asynchronous
// Notes:   register port is the internal side of the serial slave
`timescale 1ns/1ps
`include "persist_params.svh"

module persistence_and_pulse_config #(
	parameter int BASE_PULSE_CYC = `BASE_PULSE_CYC
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 nrst_i,
	input  wire persist_pkg::reg_req_s reg_req_i,
	output logic [7:0]                reg_rdata_o,
	input  wire persist_pkg::result_s prox_result_i,
	input  wire persist_pkg::result_s light_result_i,
	input  wire logic                 prox_irq_clear_i,
	input  wire logic                 light_irq_clear_i,
	input  wire logic                 prox_irq_enable_i,
	input  wire logic                 light_irq_enable_i,
	input  wire logic                 wait_tick_i,
	input  wire logic                 prox_start_i,
	input  wire logic                 near_sat_i,
	input  wire logic                 auto_pulse_ctrl_off_i,
	output logic                      prox_irq_flag_o,
	output logic                      light_irq_flag_o,
	output logic                      int_o,
	output logic                      wait_step_o,
	output logic                      emitter_o,
	output logic                      prox_cycle_done_o,
	output logic [6:0]                pulses_emitted_o
);
	import persist_pkg::*;

	persist_reg_s persistence_filters;
	config_zero_s general_config_zero;
	pulse_cfg_s   proximity_pulse_config;

	logic [3:0]  prox_cnt;
	logic [5:0]  light_cnt;
	logic [5:0]  light_target;
	logic [3:0]  wait_cnt;
	logic [2:0]  sat_sync;
	logic        near_sat;
	emit_state_e emit_state;
	logic [15:0] width_cyc;
	logic [15:0] phase_cnt;
	logic [6:0]  pulse_cnt;
	logic        next_prox_set;
	logic        next_light_set;
	logic        stop_now;

	// ==========================================
	// register port
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			persistence_filters    <= `RST_PERSISTENCE_FILTERS;
			general_config_zero    <= `RST_GENERAL_CONFIG_ZERO;
			proximity_pulse_config <= `RST_PROXIMITY_PULSE_CFG;
		end else if (reg_req_i.wr) begin
			// reserved bits store what the host writes; keeping them is its duty
			case (reg_req_i.addr)
				`ADDR_PERSISTENCE_FILTERS: persistence_filters    <= reg_req_i.wdata;
				`ADDR_GENERAL_CONFIG_ZERO: general_config_zero    <= reg_req_i.wdata;
				`ADDR_PROXIMITY_PULSE_CFG: proximity_pulse_config <= reg_req_i.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= `RDATA_UNMAPPED;
		end else begin
			case (reg_req_i.addr)
				`ADDR_PERSISTENCE_FILTERS: reg_rdata_o <= persistence_filters;
				`ADDR_GENERAL_CONFIG_ZERO: reg_rdata_o <= general_config_zero;
				`ADDR_PROXIMITY_PULSE_CFG: reg_rdata_o <= proximity_pulse_config;
				default:                   reg_rdata_o <= `RDATA_UNMAPPED;
			endcase
		end
	end

	// ==========================================
	// persistence filters
	always_comb begin
		light_target = 6'(persistence_filters.light_persist_count);
		if (persistence_filters.light_persist_count > 4'(`LIGHT_PERSIST_DIRECT_MAX)) begin
			light_target = 6'((persistence_filters.light_persist_count -
				4'(`LIGHT_PERSIST_DIRECT_MAX)) * `LIGHT_PERSIST_STEP);
		end
	end

	always_comb begin
		next_prox_set = 1'b0;
		if (prox_result_i.done) begin
			if (persistence_filters.prox_persist_count == 4'h0) begin
				next_prox_set = 1'b1;
			end else if (prox_result_i.out_of_range) begin
				next_prox_set = (prox_cnt + 4'h1) == persistence_filters.prox_persist_count;
			end
		end
	end

	always_comb begin
		next_light_set = 1'b0;
		if (light_result_i.done) begin
			if (light_target == 6'h00) begin
				next_light_set = 1'b1;
			end else if (light_result_i.out_of_range) begin
				next_light_set = (light_cnt + 6'h01) == light_target;
			end
		end
	end

	// counters saturate so a long run never wraps back onto the target
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prox_cnt <= 4'h0;
		end else if (prox_result_i.done) begin
			if (!prox_result_i.out_of_range) begin
				prox_cnt <= 4'h0;
			end else if (prox_cnt != 4'hf) begin
				prox_cnt <= prox_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			light_cnt <= 6'h00;
		end else if (light_result_i.done) begin
			if (!light_result_i.out_of_range) begin
				light_cnt <= 6'h00;
			end else if (light_cnt != 6'h3f) begin
				light_cnt <= light_cnt + 6'h01;
			end
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prox_irq_flag_o  <= 1'b0;
			light_irq_flag_o <= 1'b0;
		end else begin
			prox_irq_flag_o  <= next_prox_set | (prox_irq_flag_o & ~prox_irq_clear_i);
			light_irq_flag_o <= next_light_set | (light_irq_flag_o & ~light_irq_clear_i);
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			int_o <= 1'b0;
		end else begin
			int_o <= (prox_irq_flag_o & prox_irq_enable_i) |
				(light_irq_flag_o & light_irq_enable_i);
		end
	end

	// ==========================================
	// wait period extension
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_cnt    <= 4'h0;
			wait_step_o <= 1'b0;
		end else if (!general_config_zero.wait_extend_x12) begin
			wait_cnt    <= 4'h0;
			wait_step_o <= wait_tick_i;
		end else if (wait_tick_i) begin
			if (wait_cnt == 4'(`WAIT_EXTEND_FACTOR - 1)) begin
				wait_cnt    <= 4'h0;
				wait_step_o <= 1'b1;
			end else begin
				wait_cnt    <= wait_cnt + 4'h1;
				wait_step_o <= 1'b0;
			end
		end else begin
			wait_step_o <= 1'b0;
		end
	end

	// ==========================================
	// near-saturation synchroniser
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sat_sync <= 3'h0;
			near_sat <= 1'b0;
		end else begin
			sat_sync <= {sat_sync[1:0], near_sat_i};
			if (sat_sync[2] == sat_sync[1]) begin
				near_sat <= sat_sync[1];
			end
		end
	end

	// ==========================================
	// emitter pulse train
	always_comb begin
		width_cyc = 16'(BASE_PULSE_CYC) << proximity_pulse_config.pulse_width_sel;
		if (general_config_zero.pulse_width_x16) begin
			width_cyc = width_cyc << `PULSE_X16_SHIFT;
		end
	end

	// a pulse in flight always finishes; saturation is sampled only as a pulse ends and stops the train there
	always_comb begin
		stop_now = (pulse_cnt + 7'h01) > {1'b0, proximity_pulse_config.pulse_count_max};
		if (!auto_pulse_ctrl_off_i && near_sat) begin
			stop_now = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			emit_state        <= EMIT_IDLE;
			phase_cnt         <= 16'h0000;
			pulse_cnt         <= 7'h00;
			emitter_o         <= 1'b0;
			prox_cycle_done_o <= 1'b0;
			pulses_emitted_o  <= 7'h00;
		end else begin
			prox_cycle_done_o <= 1'b0;
			case (emit_state)
				EMIT_IDLE: begin
					if (prox_start_i) begin
						emit_state <= EMIT_PULSE;
						phase_cnt  <= width_cyc;
						pulse_cnt  <= 7'h00;
						emitter_o  <= 1'b1;
					end
				end
				EMIT_PULSE: begin
					if (phase_cnt == 16'h0001) begin
						emitter_o <= 1'b0;
						pulse_cnt <= pulse_cnt + 7'h01;
						if (stop_now) begin
							emit_state        <= EMIT_IDLE;
							prox_cycle_done_o <= 1'b1;
							pulses_emitted_o  <= pulse_cnt + 7'h01;
						end else begin
							emit_state <= EMIT_GAP;
							phase_cnt  <= width_cyc;
						end
					end else begin
						phase_cnt <= phase_cnt - 16'h0001;
					end
				end
				EMIT_GAP: begin
					if (phase_cnt == 16'h0001) begin
						emit_state <= EMIT_PULSE;
						phase_cnt  <= width_cyc;
						emitter_o  <= 1'b1;
					end else begin
						phase_cnt <= phase_cnt - 16'h0001;
					end
				end
				default: begin
					emit_state <= EMIT_IDLE;
					emitter_o  <= 1'b0;
				end
			endcase
		end
	end

endmodule

// *** src/persist_params.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 10 MHz system clock
// Notes:   included by the top module only
`ifndef PERSIST_PARAMS_SVH
`define PERSIST_PARAMS_SVH

// ==========================================
// register offsets
`define ADDR_PERSISTENCE_FILTERS   8'h8c
`define ADDR_GENERAL_CONFIG_ZERO   8'h8d
`define ADDR_PROXIMITY_PULSE_CFG   8'h8e

// ==========================================
// reset values
`define RST_PERSISTENCE_FILTERS    8'h00
`define RST_GENERAL_CONFIG_ZERO    8'h40
`define RST_PROXIMITY_PULSE_CFG    8'h4f
`define RDATA_UNMAPPED             8'h00

// ==========================================
// field positions
`define POS_PROX_PERSIST_MSB       7
`define POS_PROX_PERSIST_LSB       4
`define POS_LIGHT_PERSIST_MSB      3
`define POS_LIGHT_PERSIST_LSB      0
`define POS_WAIT_EXTEND            2
`define POS_PULSE_WIDTH_X16        0
`define POS_PULSE_WIDTH_MSB        7
`define POS_PULSE_WIDTH_LSB        6
`define POS_PULSE_COUNT_MSB        5
`define POS_PULSE_COUNT_LSB        0

// ==========================================
// timing
`define CLK_FREQ_HZ                10000000
`define BASE_PULSE_NS              4000
`define BASE_PULSE_CYC             ((`BASE_PULSE_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define WAIT_EXTEND_FACTOR         12
`define PULSE_X16_SHIFT            4
`define LIGHT_PERSIST_STEP         5
`define LIGHT_PERSIST_DIRECT_MAX   3

`endif

// *** src/persist_pkg.sv ***
// Purpose: shared types of the persistence and pulse configuration block
// Assumes: constants live in persist_params.svh
// Notes:   register layouts match the byte images on the register port
package persist_pkg;

	// ==========================================
	// register layouts
	typedef struct packed {
		logic [3:0] prox_persist_count;
		logic [3:0] light_persist_count;
	} persist_reg_s;

	typedef struct packed {
		logic [4:0] reserved_hi;
		logic       wait_extend_x12;
		logic       reserved_lo;
		logic       pulse_width_x16;
	} config_zero_s;

	typedef struct packed {
		logic [1:0] pulse_width_sel;
		logic [5:0] pulse_count_max;
	} pulse_cfg_s;

	// ==========================================
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} reg_req_s;

	// ==========================================
	// measurement result strobe
	typedef struct packed {
		logic done;
		logic out_of_range;
	} result_s;

	typedef enum logic [1:0] {
		EMIT_IDLE,
		EMIT_PULSE,
		EMIT_GAP
	} emit_state_e;

endpackage

// *** bench/persist_sva.sv ***
// Purpose: port-level checks of the persistence and pulse block
// Assumes: base pulse width handed on from the top module
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
module persist_sva #(
	parameter int BASE_PULSE_CYC = 40
) (
	input wire logic                  sys_clk_i,
	input wire logic                  nrst_i,
	input wire persist_pkg::result_s  prox_result_i,
	input wire persist_pkg::result_s  light_result_i,
	input wire logic                  prox_irq_clear_i,
	input wire logic                  prox_irq_enable_i,
	input wire logic                  light_irq_enable_i,
	input wire logic                  wait_tick_i,
	input wire logic                  prox_irq_flag_o,
	input wire logic                  light_irq_flag_o,
	input wire logic                  int_o,
	input wire logic                  wait_step_o,
	input wire logic                  emitter_o,
	input wire logic                  prox_cycle_done_o,
	input wire logic [6:0]            pulses_emitted_o
);
	import persist_pkg::*;
	int hi_cnt;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// ==========================================
	// emitter high time, cleared on every low cycle
	always_ff @(posedge sys_clk_i or negedge nrst_i)
		if (!nrst_i) hi_cnt <= 0;
		else hi_cnt <= emitter_o ? hi_cnt + 1 : 0;
	sequence s_fall;
		$fell(emitter_o);
	endsequence
	// ==========================================
	// flags, pin, train and wait
	AST_INT_PIN: assert property (1'b1 |=> int_o == ($past(prox_irq_flag_o & prox_irq_enable_i)
		| $past(light_irq_flag_o & light_irq_enable_i))) else $error("int pin wrong");
	AST_PFLAG_CAUSE: assert property ($rose(prox_irq_flag_o) |-> $past(prox_result_i.done))
		else $error("prox flag without result");
	AST_LFLAG_CAUSE: assert property ($rose(light_irq_flag_o) |-> $past(light_result_i.done))
		else $error("light flag without result");
	AST_PFLAG_HOLD: assert property (prox_irq_flag_o && !prox_irq_clear_i |=> prox_irq_flag_o)
		else $error("prox flag dropped");
	AST_PFLAG_CLR: assert property (prox_irq_clear_i && !prox_result_i.done |=> !prox_irq_flag_o)
		else $error("prox flag not cleared");
	AST_TRAIN_END: assert property (prox_cycle_done_o |-> s_fall ##1 !prox_cycle_done_o)
		else $error("train end wrong");
	AST_PULSE_CNT: assert property (prox_cycle_done_o |-> pulses_emitted_o inside {[7'h01:7'h40]})
		else $error("pulse count out of range");
	AST_PULSE_LEN: assert property (s_fall |-> hi_cnt >= BASE_PULSE_CYC)
		else $error("emitter pulse short");
	AST_WAIT_STEP: assert property (wait_step_o |-> $past(wait_tick_i))
		else $error("wait step without tick");
endmodule

bind persistence_and_pulse_config persist_sva #(.BASE_PULSE_CYC(BASE_PULSE_CYC)) persist_sva_i (
	.sys_clk_i, .nrst_i, .prox_result_i, .light_result_i, .prox_irq_clear_i, .prox_irq_enable_i,
	.light_irq_enable_i, .wait_tick_i, .prox_irq_flag_o, .light_irq_flag_o, .int_o, .wait_step_o,
	.emitter_o, .prox_cycle_done_o, .pulses_emitted_o
);

// *** bench/host_model.sv ***
// Purpose: host side of the register port
// Assumes: tasks are entered just after a clock edge
// Notes:   config byte writes keep reserved bits at default
`timescale 1ns/1ps
module host_model (
	input  wire logic             sys_clk_i,
	output persist_pkg::reg_req_s reg_req_o
);
	import persist_pkg::*;
	initial reg_req_o = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = (a == 8'h8d) ? {5'b01000, d[2], 1'b0, d[0]} : d;
		reg_req_o = '{a, 1'b1, v};
		@(posedge sys_clk_i);
		#1 reg_req_o.wr = 1'b0;
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		reg_req_o = '{a, 1'b0, 8'h00};
		@(posedge sys_clk_i);
		#1;
	endtask
endmodule

// *** bench/persistence_and_pulse_config_bench.sv ***
// Purpose: self-checking bench of the persistence and pulse block
// Assumes: base pulse of 2 cycles keeps trains short
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module persistence_and_pulse_config_bench;
	import persist_pkg::*;
	logic       sys_clk_i = 0;
	logic       nrst_i = 0;
	reg_req_s   req;
	logic [7:0] rdata;
	result_s    pres = '0;
	result_s    lres = '0;
	logic       pclr = 0, lclr = 0, pen = 1, len = 0, wtick = 0, start = 0, nsat = 0, apc_off = 1;
	logic       pflag, lflag, irq, wstep, emit, pdone;
	logic [6:0] npulse;
	int         error_cnt = 0;
	int         checked = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	host_model host_model_i (.sys_clk_i(sys_clk_i), .reg_req_o(req));
	persistence_and_pulse_config #(.BASE_PULSE_CYC(2)) persistence_and_pulse_config_i (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.prox_result_i(pres), .light_result_i(lres), .prox_irq_clear_i(pclr),
		.light_irq_clear_i(lclr), .prox_irq_enable_i(pen), .light_irq_enable_i(len),
		.wait_tick_i(wtick), .prox_start_i(start), .near_sat_i(nsat),
		.auto_pulse_ctrl_off_i(apc_off), .prox_irq_flag_o(pflag), .light_irq_flag_o(lflag),
		.int_o(irq), .wait_step_o(wstep), .emitter_o(emit), .prox_cycle_done_o(pdone),
		.pulses_emitted_o(npulse));
	// ==========================================
	// shared tasks
	task automatic tick();
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic cmp(logic [15:0] got, logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		host_model_i.rd(a);
		cmp({8'h00, rdata}, {8'h00, exp});
	endtask
	// one result strobe, then a quiet cycle
	task automatic res(bit l, bit oor);
		if (l) lres = '{1'b1, oor};
		else pres = '{1'b1, oor};
		tick();
		lres = '0;
		pres = '0;
		tick();
	endtask
	task automatic persist(bit l, int code, int n);
		host_model_i.wr(8'h8c, l ? 8'(code) : 8'(code << 4));
		res(l, 0);
		if (l) lclr = 1;
		else pclr = 1;
		tick();
		lclr = 0;
		pclr = 0;
		tick();
		if (!l) cmp(irq, 0);
		repeat (n - 1) res(l, 1);
		cmp(l ? lflag : pflag, 0);
		res(l, 1);
		cmp(l ? lflag : pflag, 1);
		if (!l) cmp(irq, 1);
	endtask
	task automatic train(logic [7:0] c0, logic [7:0] pc, int w, int np);
		int hi = 0;
		int k = 0;
		host_model_i.wr(8'h8d, c0);
		host_model_i.wr(8'h8e, pc);
		start = 1;
		tick();
		start = 0;
		// the first pulse is already high after the start edge
		hi += emit;
		// longest train is 127 widths of 128 cycles
		do begin
			tick();
			hi += emit;
			k++;
		end while (!pdone && k < 20000);
		cmp(pdone, 1);
		cmp(16'(hi), 16'(w * np));
		cmp(16'(npulse), 16'(np));
	endtask
	task automatic waits(logic [7:0] c0, int n, int exp);
		int s = 0;
		host_model_i.wr(8'h8d, c0);
		repeat (n) begin
			wtick = 1;
			tick();
			s += wstep;
			wtick = 0;
			tick();
			s += wstep;
		end
		cmp(16'(s), 16'(exp));
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================
	// tests
	initial begin
		repeat (3) tick();
		nrst_i = 1;
		rd(8'h8c, 8'h00);
		rd(8'h8d, 8'h40);
		rd(8'h8e, 8'h4f);
		rd(8'h8b, 8'h00);
		$display("test reset done");
		waits(8'h44, 24, 2);
		waits(8'h40, 5, 5);
		$display("test wait done");
		host_model_i.wr(8'h8c, 8'h00);
		res(0, 0);
		cmp(pflag, 1);
		res(1, 0);
		cmp(lflag, 1);
		for (int c = 1; c < 16; c++) begin
			persist(0, c, c);
			persist(1, c, c <= 3 ? c : (c - 3) * 5);
		end
		rd(8'h8c, 8'h0f);
		$display("test persistence done");
		for (int s = 0; s < 4; s++) train(8'h40, {2'(s), 6'(s)}, 2 << s, s + 1);
		train(8'h41, 8'hbf, 128, 64);
		rd(8'h8d, 8'h41);
		apc_off = 0;
		nsat = 1;
		train(8'h40, 8'h05, 2, 1);
		nsat = 0;
		train(8'h40, 8'h05, 2, 6);
		$display("test emitter done");
		report_and_stop();
	end
	initial begin
		#3_000_000;
		error_cnt++;
		report_and_stop();
	end
endmodule
